/* File: dv/uaf_master.sv */
// Purpose: Master end of the multidrop link, sends frames to the slave.
// Assumes: Divisor 0 in the slave, so one bit is 16 clocks.
// Notes: Line idles high between frames, like a pulled-up wire.
`timescale 1ns/1ps
`default_nettype none
module uaf_master (
  // Clock
  input wire logic i_clk,
  // Line into the slave
  output var logic o_rxd
);
  initial o_rxd = 1'b1;
  task automatic bit_out(input logic v);
    o_rxd <= v;
    repeat (16) @(posedge i_clk);
  endtask
  // Address frames carry ninth 1, data frames ninth 0
  task automatic send(input logic [7:0] b, input logic nine, input logic ninth, input logic stop);
    @(posedge i_clk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(b[i]);
    if (nine) bit_out(ninth);
    bit_out(stop);
    bit_out(1'b1);
    bit_out(1'b1);
  endtask
  // Static level, used as shift data in mode 0
  task automatic hold(input logic v);
    @(posedge i_clk);
    o_rxd <= v;
  endtask
endmodule
`default_nettype wire

/* File: dv/uaf_top_assertions.sv */
// Purpose: Port-level checks of the address filter top.
// Assumes: Register map of uaf_map.vh; shadows follow bus writes.
// Notes: Shift clock width check holds for divisor 0 only.
`timescale 1ns/1ps
`default_nettype none
`include "uaf_map.vh"
module uaf_top_chk (
  // Clock, reset and register port
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [5:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // Link and interrupt
  input wire logic I_RXD,
  input wire logic O_SHIFT_CLK,
  input wire logic O_IRQ
);
  logic [7:0] sa_q, sm_q, ct_q, bd_q;
  logic [2:0] en_q;
  logic rd_q;
  logic [5:0] ad_q;
  always @(posedge I_CLK) begin
    rd_q <= I_RD & ~I_SYS_RST;
    ad_q <= I_ADDR;
    if (I_SYS_RST) begin
      {sa_q, sm_q, ct_q, bd_q, en_q} <= {24'h0, 8'h0f, 3'h0};
    end else if (I_WR) begin
      if (I_ADDR == `UAF_OFS_SLAVE_ADDRESS) sa_q <= I_WDATA;
      if (I_ADDR == `UAF_OFS_SMASK) sm_q <= I_WDATA;
      if (I_ADDR == `UAF_OFS_CTRL) ct_q <= I_WDATA;
      if (I_ADDR == `UAF_OFS_BAUD) bd_q <= I_WDATA;
      if (I_ADDR == `UAF_OFS_ENABLE) en_q <= I_WDATA[2:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  chk_rdata_idle: assert property (!rd_q |-> O_RDATA == 8'h00)
    else $error("read data outside its slot");
  chk_slave_address_read: assert property (rd_q && ad_q == `UAF_OFS_SLAVE_ADDRESS |-> O_RDATA == sa_q)
    else $error("slave address readback wrong");
  chk_mask_read: assert property (rd_q && ad_q == `UAF_OFS_SMASK |-> O_RDATA == sm_q)
    else $error("mask readback wrong");
  chk_ctrl_read: assert property (rd_q && ad_q == `UAF_OFS_CTRL |-> O_RDATA == (ct_q & 8'hf0))
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (rd_q && (ad_q[1:0] != 2'h0 || ad_q > 6'h20) |-> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (en_q == 3'h0 |-> !O_IRQ)
    else $error("interrupt with all sources masked");
  chk_irq_sticky: assert property (O_IRQ && !(I_WR && (I_ADDR == `UAF_OFS_CLEAR || I_ADDR == `UAF_OFS_ENABLE))
    |=> O_IRQ) else $error("interrupt dropped without clear");
  chk_shift_low: assert property ($fell(O_SHIFT_CLK) && bd_q == 8'h00 |-> !O_SHIFT_CLK [*8] ##1 O_SHIFT_CLK)
    else $error("shift clock low phase not eight cycles");
  chk_shift_idle: assert property ((ct_q[7:6] != 2'h0 || !ct_q[4]) [*2] |-> O_SHIFT_CLK)
    else $error("shift clock active outside shift mode");
  cov_irq: cover property ($rose(O_IRQ));
  cov_shift: cover property ($fell(O_SHIFT_CLK));
  cov_unmapped: cover property (rd_q && ad_q > 6'h20);
endmodule
bind uaf_top uaf_top_chk u_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_RXD(I_RXD), .O_SHIFT_CLK(O_SHIFT_CLK), .O_IRQ(O_IRQ));
`default_nettype wire

/* File: dv/uaf_top_tb.sv */
// Purpose: Self-checking bench for the address filter top.
// Assumes: Register map of uaf_map.vh, divisor set to 0.
// Notes: Frames come from the master model.
`timescale 1ns/1ps
`default_nettype none
`include "uaf_map.vh"
module uaf_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire logic [7:0] rdata;
  wire logic rxd, sclk, irq;
  logic [7:0] last_rx;
  logic [7:0] tbl [5] = '{8'hf0, 8'hf1, 8'hf2, 8'hff, 8'hfb};
  // Address f1, mask fa: f0/f1 given, ff/fb broadcast, f2 neither
  logic [7:0] exp_st [5] = '{8'h01, 8'h01, 8'h04, 8'h01, 8'h01};
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  uaf_top uut (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_RXD(rxd), .O_SHIFT_CLK(sclk), .O_IRQ(irq));
  uaf_master u_master (.i_clk(clk), .o_rxd(rxd));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  // Interrupt check assumes only the receive source is enabled
  task automatic frame(input logic [7:0] b, input logic nine, input logic ninth, input logic stop,
    input logic [7:0] st);
    u_master.send(b, nine, ninth, stop);
    if (st[0]) last_rx = b;
    rd_reg(`UAF_OFS_STATUS, st);
    rd_reg(`UAF_OFS_RXBUF, last_rx);
    check({7'h0, irq}, {7'h0, st[0]});
    wr_reg(`UAF_OFS_CLEAR, 8'h07);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      final_report();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`UAF_OFS_CTRL, 8'h00);
    rd_reg(`UAF_OFS_SLAVE_ADDRESS, 8'h00);
    rd_reg(`UAF_OFS_SMASK, 8'h00);
    rd_reg(`UAF_OFS_BAUD, 8'h0f);
    rd_reg(6'h24, 8'h00);
    rd_reg(6'h02, 8'h00);
    wr_reg(`UAF_OFS_STATUS, 8'hff);
    rd_reg(`UAF_OFS_STATUS, 8'h00);
    $display("test reset_values done");
    wr_reg(`UAF_OFS_BAUD, 8'h00);
    wr_reg(`UAF_OFS_ENABLE, 8'h01);
    wr_reg(`UAF_OFS_CTRL, 8'hf0);
    frame(8'h5a, 1'h1, 1'h1, 1'h1, 8'h01);
    rd_reg(`UAF_OFS_RXINFO, 8'h01);
    frame(8'h5a, 1'h1, 1'h0, 1'h1, 8'h04);
    rd_reg(`UAF_OFS_RXINFO, 8'h01);
    wr_reg(`UAF_OFS_SLAVE_ADDRESS, 8'hf1);
    wr_reg(`UAF_OFS_SMASK, 8'hfa);
    for (int m = 2; m < 4; m++) begin
      wr_reg(`UAF_OFS_CTRL, {m[1:0], 6'h30});
      for (int i = 0; i < 5; i++) frame(tbl[i], 1'h1, 1'h1, 1'h1, exp_st[i]);
      frame(8'hf0, 1'h1, 1'h0, 1'h1, 8'h04);
    end
    $display("test nine_bit_filter done");
    wr_reg(`UAF_OFS_CTRL, 8'hd0);
    wr_reg(`UAF_OFS_ENABLE, 8'h00);
    u_master.send(8'hf2, 1'h1, 1'h0, 1'h1);
    check({7'h0, irq}, 8'h00);
    rd_reg(`UAF_OFS_STATUS, 8'h01);
    rd_reg(`UAF_OFS_RXBUF, 8'hf2);
    rd_reg(`UAF_OFS_RXINFO, 8'h00);
    wr_reg(`UAF_OFS_ENABLE, 8'h01);
    #1;
    check({7'h0, irq}, 8'h01);
    wr_reg(`UAF_OFS_CLEAR, 8'h01);
    #1;
    check({7'h0, irq}, 8'h00);
    $display("test filter_off done");
    wr_reg(`UAF_OFS_CTRL, 8'h70);
    frame(8'hff, 1'h0, 1'h0, 1'h1, 8'h01);
    frame(8'hf2, 1'h0, 1'h0, 1'h1, 8'h04);
    frame(8'hf0, 1'h0, 1'h0, 1'h0, 8'h06);
    wr_reg(`UAF_OFS_CTRL, 8'hc0);
    u_master.send(8'hff, 1'h1, 1'h1, 1'h1);
    rd_reg(`UAF_OFS_STATUS, 8'h00);
    $display("test mode1_and_disable done");
    u_master.hold(1'b0);
    wr_reg(`UAF_OFS_CTRL, 8'h30);
    // Shift clock is in the low half of the first bit here
    repeat (5) @(posedge clk);
    #1;
    check({7'h0, sclk}, 8'h00);
    repeat (155) @(posedge clk);
    rd_reg(`UAF_OFS_STATUS, 8'h01);
    rd_reg(`UAF_OFS_RXBUF, 8'h00);
    check({7'h0, sclk}, 8'h01);
    u_master.hold(1'b1);
    $display("test shift_mode done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: src/uaf_addr_match.v */
// Purpose: Given-address and broadcast-address compare of one received byte.
// Assumes: Purely combinational; caller samples the result.
// Notes: All-zero address and mask match every byte.
`timescale 1ns/1ps
`default_nettype none
module uaf_addr_match #(
  parameter WIDTH = 8
) (
  // Operands
  input wire [WIDTH-1:0] i_byte,
  input wire [WIDTH-1:0] i_addr,
  input wire [WIDTH-1:0] i_mask,
  // Result
  output wire o_given,
  output wire o_bcast,
  output wire o_match
);
  wire [WIDTH-1:0] bcast_addr;

  // Mask 0 means don't care; mask 1 means bit must equal address
  assign o_given = ~|((i_byte ^ i_addr) & i_mask);
  // Broadcast is address OR mask, zeros don't care, ones must be 1
  assign bcast_addr = i_addr | i_mask;
  assign o_bcast = ~|(~i_byte & bcast_addr);
  assign o_match = o_given | o_bcast;
endmodule
`default_nettype wire

/* File: src/uaf_map.vh */
// Purpose: Register offsets, field positions, reset values and codes for the address filter.
// Assumes: 6-bit word address, 8-bit data on the register port.
// Notes: Included by the top module, the checker and the testbench.
`ifndef UAF_MAP_VH
`define UAF_MAP_VH

// Register offsets
`define UAF_OFS_CTRL 6'h00
`define UAF_OFS_SLAVE_ADDRESS 6'h04
`define UAF_OFS_SMASK 6'h08
`define UAF_OFS_RXBUF 6'h0c
`define UAF_OFS_STATUS 6'h10
`define UAF_OFS_CLEAR 6'h14
`define UAF_OFS_ENABLE 6'h18
`define UAF_OFS_BAUD 6'h1c
`define UAF_OFS_RXINFO 6'h20

// Control register fields
`define UAF_CTRL_MODE_HI 7
`define UAF_CTRL_MODE_LO 6
`define UAF_CTRL_FILT_EN 5
`define UAF_CTRL_RX_EN 4

// Status, clear and enable register fields
`define UAF_ST_RX_DONE 0
`define UAF_ST_FRAME_ERR 1
`define UAF_ST_FILTERED 2

// Serial modes
`define UAF_MODE_SHIFT 2'h0
`define UAF_MODE_ASYNC8 2'h1
`define UAF_MODE_ASYNC9A 2'h2
`define UAF_MODE_ASYNC9B 2'h3

// Reset values
`define UAF_RST_CTRL 8'h00
`define UAF_RST_SLAVE_ADDRESS 8'h00
`define UAF_RST_SMASK 8'h00
`define UAF_RST_ENABLE 3'h0
`define UAF_RST_BAUD 8'h0f

// Timing: ticks per bit and sample points
`define UAF_TICK_MID 4'h7
`define UAF_TICK_LAST 4'hf
`define UAF_TICK_SHIFT_SAMPLE 4'h8
`define UAF_BITS_DATA 4'h8

`endif

/* File: src/uaf_tick_div.v */
// Purpose: Free-running divider giving a one-cycle tick every DIV+1 clocks.
// Assumes: Divisor may change at any time; new value takes effect at once, compared with the running count.
// Notes: Tick is the sixteen-times oversampling rate of the receiver.
`timescale 1ns/1ps
`default_nettype none
module uaf_tick_div #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Control
  input wire [WIDTH-1:0] i_div,
  // Tick
  output wire o_tick
);
  reg [WIDTH-1:0] cnt_q;
  wire wrap;

  assign wrap = (cnt_q >= i_div);
  assign o_tick = wrap;

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (wrap) begin
      cnt_q <= {WIDTH{1'b0}};
    end else begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

/* File: src/uaf_top.v */
// Purpose: Serial receiver with automatic address filter for a multidrop link.
// Assumes: Single 250 MHz clock, synchronous active-high reset, plain register port.
// Notes: Four modes; oversampled by 16 in async modes, shift clock out in mode 0.
`timescale 1ns/1ps
`default_nettype none
`include "uaf_map.vh"
module uaf_top #(
  parameter DIV_WIDTH = 8
) (
  // Clock and reset
  input wire I_CLK,
  input wire I_SYS_RST,
  // Register port
  input wire [5:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output wire [7:0] O_RDATA,
  // Serial link
  input wire I_RXD,
  output wire O_SHIFT_CLK,
  // Interrupt
  output wire O_IRQ
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_SHIFT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  reg [1:0] mode_q;
  reg filt_en_q;
  reg rx_en_q;
  reg [7:0] slave_address_q;
  reg [7:0] smask_q;
  reg [7:0] rx_buf_q;
  reg rx_ninth_q;
  reg [2:0] status_q;
  reg [2:0] status_d;
  reg [2:0] enable_q;
  reg [DIV_WIDTH-1:0] baud_q;
  reg [7:0] rdata_q;
  reg [2:0] rx_state_q;
  reg [3:0] tick_cnt_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg ninth_q;
  reg sclk_q;
  reg rxd_s1_q;
  reg rxd_s2_q;

  wire tick;
  wire addr_match;
  wire async_mode;
  wire filt_active;
  wire async_done;
  wire shift_done;
  wire stop_bit;
  wire ninth_eff;
  wire async_accept;
  wire accept;
  wire discard;
  wire [3:0] frame_bits;
  wire [2:0] ev_set;
  wire wr_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, first stage feeds only the second
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= I_RXD;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate tick and address compare
  uaf_tick_div #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_div(baud_q),
    .o_tick(tick)
  );

  uaf_addr_match #(
    .WIDTH(8)
  ) u_match (
    .i_byte(shift_q),
    .i_addr(slave_address_q),
    .i_mask(smask_q),
    .o_given(),
    .o_bcast(),
    .o_match(addr_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame decision
  assign async_mode = (mode_q != `UAF_MODE_SHIFT);
  // Mode 0 never filters; modes 1..3 filter when enabled
  assign filt_active = filt_en_q & async_mode;
  // Nine-bit modes receive one extra bit before the stop bit
  assign frame_bits = (mode_q == `UAF_MODE_ASYNC8) ? `UAF_BITS_DATA : (`UAF_BITS_DATA + 4'h1);
  assign stop_bit = rxd_s2_q;
  assign async_done = tick & (rx_state_q == ST_STOP) & (tick_cnt_q == `UAF_TICK_LAST);
  assign shift_done = tick & (rx_state_q == ST_SHIFT) & (tick_cnt_q == `UAF_TICK_LAST)
                      & (bit_cnt_q == (`UAF_BITS_DATA - 4'h1));
  // In mode 1 the stop bit stands in for the ninth bit
  assign ninth_eff = (mode_q == `UAF_MODE_ASYNC8) ? stop_bit : ninth_q;
  // Address frames need ninth=1 and a match; ninth=0 frames dropped
  // Disabled filter passes every frame, data frames included
  assign async_accept = ~filt_active | (ninth_eff & addr_match);
  // Decision taken in the stop-sample cycle itself
  assign accept = (async_done & async_accept) | shift_done;
  assign discard = async_done & ~async_accept;

  assign ev_set[`UAF_ST_RX_DONE] = accept;
  assign ev_set[`UAF_ST_FRAME_ERR] = async_done & ~stop_bit;
  assign ev_set[`UAF_ST_FILTERED] = discard;

  ////////////////////////////////////////////////////////////////////////////
  // Receive state machine
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rx_state_q <= ST_IDLE;
      tick_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ninth_q <= 1'b0;
    end else if (tick) begin
      case (rx_state_q)
        ST_IDLE: begin
          tick_cnt_q <= 4'h0;
          bit_cnt_q <= 4'h0;
          if (!async_mode) begin
            // Shift mode starts once the previous byte is taken
            if (rx_en_q && !status_q[`UAF_ST_RX_DONE]) begin
              rx_state_q <= ST_SHIFT;
            end
          end else if (rx_en_q && !stop_bit) begin
            rx_state_q <= ST_START;
          end
        end
        ST_START: begin
          tick_cnt_q <= tick_cnt_q + 4'h1;
          if (tick_cnt_q == `UAF_TICK_MID) begin
            tick_cnt_q <= 4'h0;
            // A glitch shorter than half a bit is not a start bit
            rx_state_q <= stop_bit ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          tick_cnt_q <= tick_cnt_q + 4'h1;
          if (tick_cnt_q == `UAF_TICK_LAST) begin
            if (bit_cnt_q < `UAF_BITS_DATA) begin
              shift_q <= {stop_bit, shift_q[7:1]};
            end else begin
              ninth_q <= stop_bit;
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == (frame_bits - 4'h1)) begin
              rx_state_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          tick_cnt_q <= tick_cnt_q + 4'h1;
          if (tick_cnt_q == `UAF_TICK_LAST) begin
            rx_state_q <= ST_IDLE;
          end
        end
        ST_SHIFT: begin
          tick_cnt_q <= tick_cnt_q + 4'h1;
          if (tick_cnt_q == `UAF_TICK_SHIFT_SAMPLE) begin
            shift_q <= {stop_bit, shift_q[7:1]};
          end
          if (tick_cnt_q == `UAF_TICK_LAST) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == (`UAF_BITS_DATA - 4'h1)) begin
              rx_state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          rx_state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Shift clock low in first half of each bit, data taken on its rise
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= (rx_state_q != ST_SHIFT) | tick_cnt_q[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer, loaded only for accepted frames
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rx_buf_q <= 8'h00;
      rx_ninth_q <= 1'b0;
    end else if (accept) begin
      rx_buf_q <= shift_q;
      rx_ninth_q <= async_mode & ninth_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      mode_q <= `UAF_MODE_SHIFT;
      filt_en_q <= 1'b0;
      rx_en_q <= 1'b0;
      slave_address_q <= `UAF_RST_SLAVE_ADDRESS;
      smask_q <= `UAF_RST_SMASK;
      enable_q <= `UAF_RST_ENABLE;
      baud_q <= `UAF_RST_BAUD;
    end else if (I_WR) begin
      case (I_ADDR)
        `UAF_OFS_CTRL: begin
          mode_q <= {I_WDATA[`UAF_CTRL_MODE_HI], I_WDATA[`UAF_CTRL_MODE_LO]};
          filt_en_q <= I_WDATA[`UAF_CTRL_FILT_EN];
          rx_en_q <= I_WDATA[`UAF_CTRL_RX_EN];
        end
        `UAF_OFS_SLAVE_ADDRESS: begin
          slave_address_q <= I_WDATA;
        end
        `UAF_OFS_SMASK: begin
          smask_q <= I_WDATA;
        end
        `UAF_OFS_ENABLE: begin
          enable_q <= I_WDATA[2:0];
        end
        `UAF_OFS_BAUD: begin
          baud_q <= I_WDATA[DIV_WIDTH-1:0];
        end
        default: begin
          baud_q <= baud_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new event beats a clear in the same cycle
  assign wr_clear = I_WR & (I_ADDR == `UAF_OFS_CLEAR);

  always @* begin
    status_d = status_q;
    if (wr_clear) begin
      status_d = status_q & ~I_WDATA[2:0];
    end
    status_d = status_d | ev_set;
  end

  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      status_q <= 3'h0;
    end else begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data valid in the next cycle only
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdata_q <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        `UAF_OFS_CTRL: begin
          rdata_q <= {mode_q, filt_en_q, rx_en_q, 4'h0};
        end
        `UAF_OFS_SLAVE_ADDRESS: begin
          rdata_q <= slave_address_q;
        end
        `UAF_OFS_SMASK: begin
          rdata_q <= smask_q;
        end
        `UAF_OFS_RXBUF: begin
          rdata_q <= rx_buf_q;
        end
        `UAF_OFS_STATUS: begin
          rdata_q <= {5'h00, status_q};
        end
        `UAF_OFS_ENABLE: begin
          rdata_q <= {5'h00, enable_q};
        end
        `UAF_OFS_BAUD: begin
          rdata_q <= 8'h00;
          rdata_q[DIV_WIDTH-1:0] <= baud_q;
        end
        `UAF_OFS_RXINFO: begin
          rdata_q <= {6'h00, (rx_state_q != ST_IDLE), rx_ninth_q};
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign O_RDATA = rdata_q;
  assign O_SHIFT_CLK = sclk_q;
  assign O_IRQ = |(status_q & enable_q);
endmodule
`default_nettype wire
